/* File: les_top.sv */
// line exposure sequencer: trigger, row exposure timing, strobes, gains
//
// Overview of operation
// R1: timed scheme starts exposure at accepted trigger
// R2: shorter rows start later, all end together
// R3: timed row exposure capped at 1500 us
// R4: timed minimum period is longest exposure plus 0.83us
// R5: internal timer slows to respect minimum period
// R6: faster internal rate shortens exposures, ratios kept
// R7: external trigger rate limited by exposure time
// R8: sequential scheme exposes rows 0 to 3
// R9: each row after the first has its own pre-exposure delay
// R10: sequential delay and exposure capped at 45.48us
// R11: sequential period at least sum of delays, exposures
// R12: exposure changes blank line valid for eight lines
// R13: row delay writable only in sequential scheme
// R14: exposure set per row or common to all
// R15: two or three summed stages force equal exposure
// R16: trigger goes to sensor and every strobe
// R17: trigger postpone delays sensor, not strobes
// R18: row delay follows previous row, not first row
// R19: sequential row exposures never overlap
// R20: strobe has lead, length and polarity flip
// R21: no line rate jitter in sequential scheme
// R22: per-row gains plus one common system gain
// R23: external trigger on rising, falling or both edges
// R24: strobe timing counted from the accepted trigger
`timescale 1ns/1ns
`include "les_cfg.svh"

module les_top #(
	parameter les_pkg::les_cnt_t TIMED_MAX_CYC =
		les_pkg::les_cnt_t'(`LES_TIMED_MAX_US * `LES_CLK_MHZ),
	parameter les_pkg::les_cnt_t SEQ_MAX_CYC =
		les_pkg::les_cnt_t'(`LES_SEQ_MAX_NS * `LES_CLK_MHZ / 1000)
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// register port
	input wire logic [`LES_AW-1:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [31:0] o_rdata,
	// external trigger pin
	input wire logic i_trigger_pin,
	// sensor side
	output logic [`LES_ROWS-1:0] o_row_expose,
	output logic o_readout,
	output logic o_line_valid,
	output logic [`LES_ROWS*`LES_GW-1:0] o_row_gain,
	output logic [`LES_GW-1:0] o_system_gain,
	// strobe lighting
	output logic [`LES_ROWS-1:0] o_strobe
);

	localparam les_pkg::les_cnt_t GAP_CYC =
		les_pkg::les_cnt_t'((`LES_GAP_NS * `LES_CLK_MHZ + 999) / 1000);

	les_pkg::les_state_s st;
	les_pkg::les_state_s next_st;

	// ==========================================================
	// helpers
	function automatic les_pkg::les_cnt_t cap(input les_pkg::les_cnt_t v,
		input les_pkg::les_cnt_t lim);
		cap = (v > lim) ? lim : v;
	endfunction

	function automatic logic [1:0] reg_row(input logic [`LES_AW-1:0] a);
		reg_row = a[3:2];
	endfunction

	function automatic logic [3:0] reg_group(input logic [`LES_AW-1:0] a);
		reg_group = a[7:4];
	endfunction

	// ==========================================================
	// effective exposure, delays and line period
	logic seq;
	logic [`LES_ROWS-1:0][`LES_CW-1:0] eff;
	logic [`LES_ROWS-1:0][`LES_CW-1:0] dly;
	les_pkg::les_cnt_t max_raw;
	les_pkg::les_cnt_t max_eff;
	les_pkg::les_cnt_t min_per;
	les_pkg::les_cnt_t eff_period;
	logic [2:0] shift;
	logic [`LES_ROWS-1:0][`LES_CW-1:0] raw;

	always_comb begin
		seq = st.ctrl[`LES_C_SEQ];
		max_raw = '0;
		for (int r = 0; r < `LES_ROWS; r++) begin
			// any stage setting other than one overrides the per-row choice [R15]
			raw[r] = (st.ctrl[`LES_C_STAGES] == `LES_STAGES_ONE) ? st.expo[r] : st.expo[0];
			raw[r] = cap(raw[r], seq ? SEQ_MAX_CYC : TIMED_MAX_CYC); // [R3] [R10]
			dly[r] = (r == 0) ? '0 : cap(st.delay[r], SEQ_MAX_CYC); // [R18] [R10]
			if (raw[r] > max_raw) begin
				max_raw = raw[r];
			end
		end
		// power-of-two scaling divides every row by one factor without a divider; low bits truncate [R6]
		shift = '0;
		if (!seq && !st.ctrl[`LES_C_EXT] && st.ctrl[`LES_C_RATE_PRI]) begin
			shift = `LES_MAX_SHIFT;
			for (int k = 7; k >= 0; k--) begin
				if ((max_raw >> k) + GAP_CYC <= st.period) begin
					shift = 3'(k);
				end
			end
		end
		max_eff = max_raw >> shift;
		for (int r = 0; r < `LES_ROWS; r++) begin
			eff[r] = raw[r] >> shift;
		end
		if (seq) begin
			min_per = '0;
			for (int r = 0; r < `LES_ROWS; r++) begin
				min_per = min_per + eff[r] + dly[r]; // [R11]
			end
		end else begin
			min_per = max_eff + GAP_CYC; // [R4]
		end
		eff_period = (st.period < min_per) ? min_per : st.period; // [R5]
	end

	// ==========================================================
	// trigger acceptance
	logic edge_hit;
	logic fire;
	logic accept;

	always_comb begin
		case (les_pkg::les_edge_e'(st.ctrl[`LES_C_EDGE])) // [R23]
			les_pkg::LES_EDGE_RISE: edge_hit = st.sync[1] & ~st.sync[2];
			les_pkg::LES_EDGE_FALL: edge_hit = ~st.sync[1] & st.sync[2];
			default: edge_hit = st.sync[1] ^ st.sync[2];
		endcase
		if (st.ctrl[`LES_C_EXT]) begin
			// one spare bit so a saturated since count cannot wrap to zero
			fire = edge_hit && ({1'b0, st.since} + 19'h00001 >= {1'b0, min_per}); // [R7]
		end else begin
			fire = ({1'b0, st.timer} + 19'h00001 >= {1'b0, eff_period}); // [R21]
		end
		accept = fire && (st.phase == les_pkg::LES_IDLE);
	end

	// ==========================================================
	// next state
	always_comb begin
		next_st = st;
		next_st.readout = 1'b0;
		next_st.line_valid = 1'b0;
		next_st.sync = {st.sync[1:0], i_trigger_pin};
		if (~&st.since) begin
			next_st.since = st.since + 1'b1;
		end
		next_st.timer = fire ? '0 : st.timer + 1'b1;
		if (accept) begin
			next_st.since = '0;
		end

		// sensor sequence
		case (st.phase)
			les_pkg::LES_IDLE: begin
				if (accept) begin
					next_st.phase = les_pkg::LES_POSTPONE; // [R16]
					next_st.cnt = st.postpone; // [R17]
				end
			end
			les_pkg::LES_POSTPONE: begin
				if (st.cnt == '0) begin
					next_st.row = '0;
					if (seq) begin
						next_st.phase = les_pkg::LES_SEQ_EXPO; // [R8] [R18]
						next_st.cnt = eff[0];
					end else begin
						next_st.phase = les_pkg::LES_TIMED; // [R1]
						next_st.cnt = max_eff;
					end
				end else begin
					next_st.cnt = st.cnt - 1'b1;
				end
			end
			les_pkg::LES_TIMED: begin
				if (st.cnt <= 18'h00001) begin
					next_st.phase = les_pkg::LES_IDLE; // [R2]
					next_st.cnt = '0;
					next_st.readout = 1'b1;
				end else begin
					next_st.cnt = st.cnt - 1'b1;
				end
			end
			les_pkg::LES_SEQ_DELAY: begin
				if (st.cnt <= 18'h00001) begin
					next_st.phase = les_pkg::LES_SEQ_EXPO;
					next_st.cnt = eff[st.row];
				end else begin
					next_st.cnt = st.cnt - 1'b1;
				end
			end
			les_pkg::LES_SEQ_EXPO: begin
				if (st.cnt > 18'h00001) begin
					next_st.cnt = st.cnt - 1'b1;
				end else if (st.row == 2'h3) begin
					next_st.phase = les_pkg::LES_IDLE;
					next_st.cnt = '0;
					next_st.readout = 1'b1;
				end else begin
					// the next row starts only after this one ends [R19] [R9]
					next_st.row = st.row + 1'b1;
					if (dly[st.row + 1'b1] == '0) begin
						next_st.cnt = eff[st.row + 1'b1];
					end else begin
						next_st.phase = les_pkg::LES_SEQ_DELAY;
						next_st.cnt = dly[st.row + 1'b1];
					end
				end
			end
			default: begin
				next_st.phase = les_pkg::LES_IDLE;
			end
		endcase

		for (int r = 0; r < `LES_ROWS; r++) begin
			if (next_st.phase == les_pkg::LES_TIMED) begin
				// shorter rows stay in reset until their window opens [R2]
				next_st.expose[r] = (next_st.cnt != '0) && (next_st.cnt <= eff[r]);
			end else begin
				next_st.expose[r] = (next_st.phase == les_pkg::LES_SEQ_EXPO) &&
					(next_st.row == 2'(r));
			end
		end

		if (next_st.readout) begin
			next_st.line_valid = (st.blank == '0); // [R12]
			if (st.blank != '0) begin
				next_st.blank = st.blank - 1'b1;
			end
		end

		// strobes run from the trigger itself, ahead of the postpone [R16] [R24]
		for (int s = 0; s < `LES_ROWS; s++) begin
			case (les_pkg::les_stb_e'(st.stb_ph[s]))
				les_pkg::LES_STB_LEAD: begin
					if (st.stb_cnt[s] == '0) begin
						next_st.stb_ph[s] = (st.length[s] == '0) ? 2'(les_pkg::LES_STB_IDLE) :
							2'(les_pkg::LES_STB_ON);
						next_st.stb_cnt[s] = st.length[s];
					end else begin
						next_st.stb_cnt[s] = st.stb_cnt[s] - 1'b1;
					end
				end
				les_pkg::LES_STB_ON: begin
					if (st.stb_cnt[s] <= 18'h00001) begin
						next_st.stb_ph[s] = 2'(les_pkg::LES_STB_IDLE);
					end
					next_st.stb_cnt[s] = st.stb_cnt[s] - 1'b1;
				end
				default: begin
					next_st.stb_ph[s] = 2'(les_pkg::LES_STB_IDLE);
				end
			endcase
			if (accept && st.strobe_cfg[4 + s]) begin
				next_st.stb_ph[s] = 2'(les_pkg::LES_STB_LEAD); // [R20]
				next_st.stb_cnt[s] = st.lead[s];
			end
			next_st.strobe[s] = (next_st.stb_ph[s] == 2'(les_pkg::LES_STB_ON)) ^
				st.strobe_cfg[s]; // [R20]
		end

		// register writes; a blanking restart wins over the readout decrement
		if (i_wr) begin
			case (i_addr)
				`LES_A_CTRL: begin
					next_st.ctrl = i_wdata[7:0];
					next_st.blank = `LES_BLANK_LINES; // [R12]
				end
				`LES_A_PERIOD: next_st.period = i_wdata[`LES_CW-1:0];
				`LES_A_POSTPONE: next_st.postpone = i_wdata[`LES_CW-1:0];
				`LES_A_STROBE_CFG: next_st.strobe_cfg = i_wdata[7:0];
				`LES_A_SYS_GAIN: next_st.sys_gain = i_wdata[`LES_GW-1:0]; // [R22]
				default: begin
					case (reg_group(i_addr))
						`LES_G_EXPO: begin
							for (int r = 0; r < `LES_ROWS; r++) begin
								if (st.ctrl[`LES_C_PER_ROW] ? (reg_row(i_addr) == 2'(r)) : 1'b1) begin
									next_st.expo[r] = i_wdata[`LES_CW-1:0]; // [R14]
								end
							end
							next_st.blank = `LES_BLANK_LINES; // [R12]
						end
						`LES_G_DELAY: begin
							if (seq) begin
								next_st.delay[reg_row(i_addr)] = i_wdata[`LES_CW-1:0]; // [R13]
								next_st.blank = `LES_BLANK_LINES;
							end
						end
						`LES_G_GAIN: next_st.gain[reg_row(i_addr)] = i_wdata[`LES_GW-1:0]; // [R22]
						`LES_G_LEAD: next_st.lead[reg_row(i_addr)] = i_wdata[`LES_CW-1:0];
						`LES_G_LENGTH: next_st.length[reg_row(i_addr)] = i_wdata[`LES_CW-1:0];
						default: ;
					endcase
				end
			endcase
		end

		// reads answer next cycle; unmapped addresses read zero
		next_st.rdata = '0;
		if (i_rd) begin
			case (i_addr)
				`LES_A_CTRL: next_st.rdata = {24'h000000, st.ctrl};
				`LES_A_PERIOD: next_st.rdata = {14'h0000, st.period};
				`LES_A_POSTPONE: next_st.rdata = {14'h0000, st.postpone};
				`LES_A_STROBE_CFG: next_st.rdata = {24'h000000, st.strobe_cfg};
				`LES_A_SYS_GAIN: next_st.rdata = {24'h000000, st.sys_gain};
				`LES_A_STATUS: next_st.rdata = {2'h0, st.expose, 1'b0, st.phase, st.blank,
					min_per[`LES_CW-1:0]};
				default: begin
					case (reg_group(i_addr))
						`LES_G_EXPO: next_st.rdata = {14'h0000, st.expo[reg_row(i_addr)]};
						`LES_G_DELAY: next_st.rdata = {14'h0000, st.delay[reg_row(i_addr)]};
						`LES_G_GAIN: next_st.rdata = {24'h000000, st.gain[reg_row(i_addr)]};
						`LES_G_LEAD: next_st.rdata = {14'h0000, st.lead[reg_row(i_addr)]};
						`LES_G_LENGTH: next_st.rdata = {14'h0000, st.length[reg_row(i_addr)]};
						default: next_st.rdata = '0;
					endcase
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			st <= '0;
			st.ctrl <= `LES_RST_CTRL;
			st.period <= `LES_RST_PERIOD;
			st.expo <= {`LES_ROWS{`LES_RST_EXPO}};
			st.phase <= les_pkg::LES_IDLE;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_row_expose = st.expose;
	assign o_readout = st.readout;
	assign o_line_valid = st.line_valid;
	assign o_row_gain = st.gain;
	assign o_system_gain = st.sys_gain;
	assign o_strobe = st.strobe;

	// ==========================================================
	// checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	property p_timed_start;
		accept && !seq && st.postpone == '0 |-> ##2 st.phase == les_pkg::LES_TIMED;
	endproperty
	a_timed_start: assert property (p_timed_start) else $error("timed start late"); // [R1]

	property p_common_end;
		st.phase == les_pkg::LES_TIMED && st.cnt <= 18'h00001 |=> st.readout && st.expose == '0;
	endproperty
	a_common_end: assert property (p_common_end) else $error("rows end apart"); // [R2]

	property p_timed_cap;
		st.phase == les_pkg::LES_TIMED |-> st.cnt <= TIMED_MAX_CYC;
	endproperty
	a_timed_cap: assert property (p_timed_cap) else $error("timed exposure over cap"); // [R3]

	property p_ext_spacing;
		st.ctrl[`LES_C_EXT] && $rose(st.phase == les_pkg::LES_POSTPONE) |->
			{1'b0, $past(st.since)} + 19'h00001 >= {1'b0, $past(min_per)};
	endproperty
	a_ext_spacing: assert property (p_ext_spacing) else $error("trigger too soon"); // [R7]

	property p_first_row;
		st.phase == les_pkg::LES_SEQ_EXPO && $past(st.phase) == les_pkg::LES_POSTPONE |->
			st.row == 2'h0 && st.expose == 4'h1;
	endproperty
	a_first_row: assert property (p_first_row) else $error("sequence not at row zero"); // [R8]

	property p_seq_delay_cap;
		st.phase == les_pkg::LES_SEQ_DELAY |-> st.cnt <= SEQ_MAX_CYC && st.row != 2'h0;
	endproperty
	a_seq_delay_cap: assert property (p_seq_delay_cap) else $error("bad row delay"); // [R10]

	property p_no_overlap;
		seq |-> $onehot0(st.expose);
	endproperty
	a_no_overlap: assert property (p_no_overlap) else $error("row exposures overlap"); // [R19]

	property p_blank;
		st.readout |-> st.line_valid == ($past(st.blank) == 4'h0);
	endproperty
	a_blank: assert property (p_blank) else $error("line valid during blanking"); // [R12]

	property p_delay_locked;
		i_wr && reg_group(i_addr) == `LES_G_DELAY && !seq |=> $stable(st.delay);
	endproperty
	a_delay_locked: assert property (p_delay_locked) else $error("delay written in timed"); // [R13]

endmodule

/* File: les_cfg.svh */
// constants for the line exposure sequencer: widths, offsets, fields, timing
`ifndef LES_CFG_SVH
`define LES_CFG_SVH

// ==========================================================
// widths
`define LES_CW 18
`define LES_AW 8
`define LES_GW 8
`define LES_ROWS 4

// ==========================================================
// timing, in printed units, and clock rate
`define LES_CLK_MHZ 125
`define LES_TIMED_MAX_US 1500
`define LES_SEQ_MAX_NS 45480
`define LES_GAP_NS 830
`define LES_BLANK_LINES 4'h8
`define LES_MAX_SHIFT 3'h7

// ==========================================================
// register byte addresses, then row group numbers taken from address bits 7:4
`define LES_A_CTRL 8'h00
`define LES_A_PERIOD 8'h04
`define LES_A_POSTPONE 8'h08
`define LES_A_STROBE_CFG 8'h0c
`define LES_A_SYS_GAIN 8'h10
`define LES_A_STATUS 8'h14
`define LES_G_EXPO 4'h2
`define LES_G_DELAY 4'h3
`define LES_G_GAIN 4'h4
`define LES_G_LEAD 4'h5
`define LES_G_LENGTH 4'h6

// ==========================================================
// control register fields
`define LES_C_SEQ 0
`define LES_C_EXT 1
`define LES_C_EDGE 3:2
`define LES_C_RATE_PRI 4
`define LES_C_PER_ROW 5
`define LES_C_STAGES 7:6
`define LES_STAGES_ONE 2'h1

// ==========================================================
// reset values
`define LES_RST_CTRL 8'h40
`define LES_RST_PERIOD 18'h03e80
`define LES_RST_EXPO 18'h00400

`endif

/* File: les_pkg.sv */
// types shared by the line exposure sequencer
package les_pkg;
`include "les_cfg.svh"

	typedef logic [`LES_CW-1:0] les_cnt_t;

	typedef enum logic [1:0] {LES_EDGE_RISE, LES_EDGE_FALL, LES_EDGE_ANY} les_edge_e;

	typedef enum logic [2:0] {LES_IDLE, LES_POSTPONE, LES_TIMED, LES_SEQ_DELAY,
		LES_SEQ_EXPO} les_phase_e;

	typedef enum logic [1:0] {LES_STB_IDLE, LES_STB_LEAD, LES_STB_ON} les_stb_e;

	typedef struct packed {
		logic [7:0] ctrl;
		les_cnt_t period;
		les_cnt_t postpone;
		logic [7:0] strobe_cfg;
		logic [`LES_GW-1:0] sys_gain;
		logic [`LES_ROWS-1:0][`LES_CW-1:0] expo;
		logic [`LES_ROWS-1:0][`LES_CW-1:0] delay;
		logic [`LES_ROWS-1:0][`LES_GW-1:0] gain;
		logic [`LES_ROWS-1:0][`LES_CW-1:0] lead;
		logic [`LES_ROWS-1:0][`LES_CW-1:0] length;
		logic [31:0] rdata;
		logic [2:0] sync;
		les_phase_e phase;
		les_cnt_t cnt;
		logic [1:0] row;
		les_cnt_t since;
		les_cnt_t timer;
		logic [3:0] blank;
		logic line_valid;
		logic readout;
		logic [`LES_ROWS-1:0] expose;
		logic [`LES_ROWS-1:0][`LES_CW-1:0] stb_cnt;
		logic [`LES_ROWS-1:0][1:0] stb_ph;
		logic [`LES_ROWS-1:0] strobe;
	} les_state_s;
endpackage

/* File: les_far.sv */
// far side model: trigger pin source and row overlap watch
`timescale 1ns/1ns

module les_far (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst,
	// commands from the bench
	input wire logic i_level,
	input wire logic i_seq,
	// sensor rows
	input wire logic [3:0] i_rows,
	// trigger pin and overlap flag
	output logic o_pin,
	output logic o_overlap
);
	// ==========================================================
	// pin follows the bench level one edge later, like a real source
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_pin <= 1'b0;
			o_overlap <= 1'b0;
		end else begin
			o_pin <= i_level;
			// sticky, so a single-cycle overlap is not lost
			if (i_seq && !$onehot0(i_rows)) begin
				o_overlap <= 1'b1;
			end
		end
	end
endmodule

/* File: tb.sv */
// self-checking bench for the line exposure sequencer
`timescale 1ns/1ns
`include "les_cfg.svh"

module tb;
	// ==========================================================
	// signals
	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [31:0] i_wdata = 32'h0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic lvl = 1'b0;
	logic seq = 1'b0;
	logic pin, overlap, o_readout, o_line_valid;
	logic [31:0] o_rdata, o_row_gain, d;
	logic [3:0] o_row_expose, o_strobe;
	logic [7:0] o_system_gain;
	int mismatches = 0;
	int check_count = 0;
	int cnt[4], first[4], scnt[4], ro, lv, rfirst, sfirst, ro1;

	always #4 i_clock = ~i_clock;

	// short caps keep the run brief
	les_top #(.TIMED_MAX_CYC(18'h000c8), .SEQ_MAX_CYC(18'h00028)) uut (
		.i_clock(i_clock), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_trigger_pin(pin),
		.o_row_expose(o_row_expose), .o_readout(o_readout),
		.o_line_valid(o_line_valid), .o_row_gain(o_row_gain),
		.o_system_gain(o_system_gain), .o_strobe(o_strobe));

	les_far far (.i_clock(i_clock), .i_rst(i_rst), .i_level(lvl), .i_seq(seq),
		.i_rows(o_row_expose), .o_pin(pin), .o_overlap(overlap));

	// ==========================================================
	// tasks
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		@(negedge i_clock);
		v = o_rdata;
	endtask

	task automatic setl(input logic v);
		@(posedge i_clock);
		lvl <= v;
	endtask

	// watch n cycles; row figures cover the first line only
	task automatic obs(input int n);
		bit done;
		done = 0;
		ro = 0;
		lv = 0;
		rfirst = -1;
		sfirst = -1;
		for (int r = 0; r < 4; r++) begin
			cnt[r] = 0;
			first[r] = -1;
			scnt[r] = 0;
		end
		for (int i = 0; i < n; i++) begin
			@(negedge i_clock);
			for (int r = 0; r < 4; r++) begin
				if (o_row_expose[r] && !done) begin
					if (first[r] < 0) first[r] = i;
					cnt[r]++;
				end
				if (o_strobe[r]) scnt[r]++;
			end
			if (o_strobe[0] && sfirst < 0) sfirst = i;
			if (o_readout) begin
				if (rfirst < 0) rfirst = i;
				done = 1;
				ro++;
			end
			if (o_line_valid) lv++;
		end
	endtask

	task automatic sync_ro();
		int k;
		k = 0;
		do begin
			@(negedge i_clock);
			k++;
		end while (o_readout !== 1'b1 && k < 1000);
		if (k == 1000) begin
			mismatches++;
			end_of_test();
		end
	endtask

	// ==========================================================
	// scenarios
	initial begin
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(8'h00, d); chk(d, 32'h40);
		rd(8'h04, d); chk(d, 32'h3e80);
		rd(8'h24, d); chk(d, 32'h400);
		rd(8'h7c, d); chk(d, 32'h0);
		$display("test reset done");
		// timed, external, any edge, per-row exposure
		wr(8'h00, 32'h6a);
		wr(8'h34, 32'h5);
		rd(8'h34, d); chk(d, 32'h0);
		wr(8'h20, 32'h3);
		wr(8'h24, 32'h1);
		wr(8'h28, 32'h1);
		wr(8'h2c, 32'h1);
		rd(8'h14, d); chk(d[17:0], 32'h6b);
		// the spacing guard counts from reset, so let a full minimum period pass
		repeat (120) @(posedge i_clock);
		for (int i = 1; i <= 9; i++) begin
			setl(~lvl);
			obs(150);
			chk(cnt[0], 32'h3);
			chk(cnt[3], 32'h1);
			chk(first[0] + 3, first[1] + 1);
			chk(first[1], first[3]);
			chk(ro, 32'h1);
			chk(lv, (i == 9));
		end
		setl(~lvl);
		obs(20);
		ro1 = ro;
		setl(~lvl);
		obs(200);
		chk(ro1 + ro, 32'h1);
		setl(1'b0);
		obs(150);
		for (int e = 0; e < 3; e++) begin
			wr(8'h00, 32'h62 | (e << 2));
			setl(1'b1); obs(150); chk(ro, (e != 1));
			setl(1'b0); obs(150); chk(ro, (e != 0));
		end
		$display("test timed done");
		wr(8'h00, 32'h6a);
		wr(8'h20, 32'h3e8);
		// the longer exposure raises the minimum period past the last line's age
		repeat (200) @(posedge i_clock);
		setl(~lvl);
		obs(400);
		chk(cnt[0], 32'hc8);
		rd(8'h14, d); chk(d[17:0], 32'h130);
		wr(8'h00, 32'haa);
		wr(8'h20, 32'h5);
		setl(~lvl);
		obs(150);
		for (int r = 0; r < 4; r++) chk(cnt[r], 32'h5);
		wr(8'h00, 32'h4a);
		wr(8'h20, 32'h7);
		rd(8'h2c, d); chk(d, 32'h7);
		$display("test caps done");
		// sequential: delays 2,3,4 and exposures 2,3,4,capped
		@(posedge i_clock);
		seq <= 1'b1;
		wr(8'h00, 32'h6b);
		for (int r = 1; r < 4; r++) wr(8'h30 + 4 * r, r + 1);
		for (int r = 0; r < 4; r++) wr(8'h20 + 4 * r, (r == 3) ? 100 : r + 2);
		rd(8'h38, d); chk(d, 32'h3);
		setl(~lvl);
		obs(300);
		for (int r = 0; r < 4; r++) chk(cnt[r], (r == 3) ? 40 : r + 2);
		for (int r = 1; r < 4; r++) chk(first[r], first[r-1] + cnt[r-1] + r + 1);
		chk(ro, 32'h1);
		chk(overlap, 1'b0);
		rd(8'h14, d); chk(d[17:0], 32'h3a);
		@(posedge i_clock);
		seq <= 1'b0;
		$display("test sequential done");
		// strobes 0 and 1 enabled, strobe 1 flipped, sensor postponed
		wr(8'h00, 32'h6a);
		wr(8'h0c, 32'h32);
		// the strobe flop picks up the new flip one edge after the write lands
		repeat (2) @(negedge i_clock);
		chk(o_strobe, 4'h2);
		wr(8'h50, 32'h3);
		wr(8'h60, 32'h4);
		wr(8'h64, 32'h2);
		wr(8'h68, 32'h4);
		wr(8'h08, 32'ha);
		setl(~lvl);
		obs(150);
		chk(scnt[0], 32'h4);
		chk(150 - scnt[1], 32'h2);
		chk(scnt[2], 32'h0);
		chk(sfirst < first[0], 1'b1);
		chk(sfirst, 32'h8);
		wr(8'h48, 32'h5a);
		wr(8'h10, 32'ha5);
		@(negedge i_clock);
		chk(o_row_gain[23:16], 8'h5a);
		chk(o_system_gain, 8'ha5);
		$display("test strobe done");
		// internal timer against a too-short period
		wr(8'h08, 32'h0);
		wr(8'h00, 32'h60);
		wr(8'h04, 32'h96);
		for (int r = 0; r < 4; r++) wr(8'h20 + 4 * r, (r == 0) ? 160 : (r == 1) ? 80 : 40);
		sync_ro();
		sync_ro();
		obs(400);
		chk(rfirst, 32'h107);
		wr(8'h00, 32'h70);
		sync_ro();
		sync_ro();
		obs(400);
		chk(rfirst, 32'h95);
		chk(cnt[0], 32'h28);
		chk(cnt[1], 32'h14);
		chk(cnt[3], 32'ha);
		chk(ro, 32'h2);
		$display("test internal done");
		end_of_test();
	end
endmodule
